/* File: logic/tvic_pkg.sv */
//******************************************************************************
// Purpose: Shared constants and types of the two level vectored irq controller.
// Assumes: Seventeen arbitration positions, two of them reserved.
// Notes:   Shared widths, masks, register reset values and timing figures live here.
//******************************************************************************
package tvic_pkg;

   //***************************************************************************
   // Arbitration positions and vectors.
   //***************************************************************************
   localparam int          NUM_POS      = 17;
   localparam int          POS_W        = 5;
   localparam int          NUM_USABLE   = 15;
   localparam logic [16:0] VALID_POS    = 17'h19fff;
   localparam logic [16:0] HW_CLR_POS   = 17'h0000f;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] VECTOR_BASE  = 16'h0003;
   localparam int          VECTOR_SHIFT = 3;

   //***************************************************************************
   // Special function register select lines and field layout.
   //***************************************************************************
   localparam int          NUM_REGS     = 6;
   localparam int          SEL_EN0      = 0;
   localparam int          SEL_EN1      = 1;
   localparam int          SEL_EN2      = 2;
   localparam int          SEL_PR0      = 3;
   localparam int          SEL_PR1      = 4;
   localparam int          SEL_PR2      = 5;
   localparam int          GLOBAL_BIT   = 7;
   localparam int          BASIC_FIRST  = 0;
   localparam int          BASIC_COUNT  = 7;
   localparam int          EXT1_FIRST   = 7;
   localparam int          EXT1_COUNT   = 6;
   localparam int          EXT2_FIRST   = 15;
   localparam int          EXT2_COUNT   = 2;
   localparam logic [7:0]  EXT1_MASK    = 8'h3f;
   localparam logic [7:0]  EXT2_MASK    = 8'h03;
   localparam logic [7:0]  PR0_READ_ONE = 8'h80;
   localparam logic [7:0]  REG_RESET    = 8'h00;
   localparam logic [7:0]  PR0_RESET    = 8'h80;

   //***************************************************************************
   // Response timing in system clock cycles.
   //***************************************************************************
   localparam int          DETECT_CYC   = 1;
   localparam int          CALL_CYC     = 4;
   localparam int          MIN_RESP_CYC = DETECT_CYC + CALL_CYC;
   localparam int          RETURN_FROM_INTERRUPT_INSTR_CYC     = 5;
   localparam int          DIV_CYC      = 8;
   localparam int          MAX_RESP_CYC = DETECT_CYC + RETURN_FROM_INTERRUPT_INSTR_CYC + DIV_CYC + CALL_CYC;

   //***************************************************************************
   // Controller state.
   //***************************************************************************
   typedef enum logic [1:0] {
      ST_RUN,
      ST_CALL,
      ST_HOLD
   } tvic_mode_t;

   typedef struct packed {
      tvic_mode_t        mode;
      logic [16:0]       pend;
      logic [7:0]        en0;
      logic [7:0]        en1;
      logic [7:0]        en2;
      logic [7:0]        pr0;
      logic [7:0]        pr1;
      logic [7:0]        pr2;
      logic              act_hi;
      logic              act_lo;
      logic              req;
      logic              lvl;
      logic [POS_W-1:0]  pos;
      logic [15:0]       vec;
   } tvic_state_t;

endpackage : tvic_pkg

/* File: logic/tvic_arbiter.sv */
//******************************************************************************
// Purpose: Two level fixed order arbiter over the arbitration positions.
// Assumes: Inputs already gated by enables; position 0 ranks first.
// Notes:   Purely combinational; the controller registers its result.
//******************************************************************************
`timescale 1ns/1ps
module tvic_arbiter #(
   parameter int N_SRC = 17,
   parameter int POS_W = 5
) (
   input  wire logic [N_SRC-1:0] cand,
   input  wire logic [N_SRC-1:0] high,
   output logic                  found,
   output logic [POS_W-1:0]      pos,
   output logic                  level
);

   //***************************************************************************
   // Elaboration checks.
   //***************************************************************************
   if (N_SRC > (1 << POS_W)) begin : g_bad_width
      $error("tvic_arbiter: POS_W too narrow for N_SRC");
   end
   if (N_SRC != tvic_pkg::NUM_POS) begin : g_bad_count
      $error("tvic_arbiter: N_SRC must match the position count");
   end

   // Lowest set position, used once per priority level.
   function automatic logic [POS_W:0] first_set(input logic [N_SRC-1:0] v);
      logic [POS_W:0] r;
      r = '0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, POS_W'(i)};
         end
      end
      return r;
   endfunction : first_set

   logic [POS_W:0] hi_pick;
   logic [POS_W:0] lo_pick;

   // High level requests win outright; order only splits equal levels.
   always_comb begin
      hi_pick = first_set(cand & high);
      lo_pick = first_set(cand & ~high);
      if (hi_pick[POS_W]) begin
         found = 1'b1;
         pos   = hi_pick[POS_W-1:0];
         level = 1'b1;
      end else begin
         found = lo_pick[POS_W];
         pos   = lo_pick[POS_W-1:0];
         level = 1'b0;
      end
   end

endmodule : tvic_arbiter

/* File: logic/tvic_ctrl.sv */
//******************************************************************************
// Purpose: Two level vectored interrupt controller for a small CPU core.
// Assumes: Core pulses ack at call start, return_done and instr_done at ends.
// Notes:   Enable and priority registers are written through select strobes.
//******************************************************************************
// Summary of operation
// - A source event always sets its pending flag, enabled or not.
// - Enabled pending flag raises a request; core then calls the vector.
// - Global enable bit 7 must be set before any request can appear.
// - Pending flag of a disabled source stays set and requests nothing.
// - Enables map to basic bits 0-6, extended-1 bits 0-5, extended-2 bits 0-1.
// - Call start clears flags of positions 0 to 3 only.
// - Flag still set after return re-requests after one more instruction.
// - Software setting a flag acts exactly like a hardware event.
// - High may preempt low; nothing preempts a running high routine.
// - All priority bits reset to low except bit 7 of the basic register, which reads one.
// - Higher level wins; equal levels go to lowest position.
// - Requests are sampled every cycle; request appears one cycle after flag.
// - Request pending during return waits one instruction before the call.
// - Equal or higher running routine holds new request until return plus one.
// - Vector is 0x0003 plus eight times position; reset vector 0x0000.
// - Fifteen usable sources, two levels; reset ranks above all.
`timescale 1ns/1ps
module tvic_ctrl (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [16:0] src_event,
   input  wire logic [16:0] flag_set_sw,
   input  wire logic [16:0] flag_clr_sw,
   input  wire logic [5:0]  cfg_wr_sel,
   input  wire logic [7:0]  cfg_wr_data,
   input  wire logic        cpu_ack,
   input  wire logic        cpu_return_done,
   input  wire logic        cpu_instr_done,
   output logic             irq_req,
   output logic [15:0]      irq_vector,
   output logic             irq_level,
   output logic [4:0]       irq_pos,
   output logic [16:0]      pending,
   output logic [7:0]       irq_enable_reg,
   output logic [7:0]       ext_irq_enable_reg1,
   output logic [7:0]       ext_irq_enable_reg2,
   output logic [7:0]       irq_priority_reg,
   output logic [7:0]       ext_irq_priority_reg1,
   output logic [7:0]       ext_irq_priority_reg2,
   output logic             active_high,
   output logic             active_low
);

   //***************************************************************************
   // State and decode.
   //***************************************************************************
   tvic_pkg::tvic_state_t     st_reg;
   tvic_pkg::tvic_state_t     st_next;
   logic [16:0]               en_mask;
   logic [16:0]               hi_mask;
   logic [16:0]               cand;
   logic                      win_found;
   logic [4:0]                win_pos;
   logic                      win_level;
   logic                      preempt_ok;

   // Spread three byte registers over the position map, reserved slots zero.
   function automatic logic [16:0] spread(input logic [7:0] b0,
                                          input logic [7:0] b1,
                                          input logic [7:0] b2);
      logic [16:0] m;
      m = '0;
      for (int i = 0; i < tvic_pkg::BASIC_COUNT; i++) begin
         m[tvic_pkg::BASIC_FIRST + i] = b0[i];
      end
      for (int i = 0; i < tvic_pkg::EXT1_COUNT; i++) begin
         m[tvic_pkg::EXT1_FIRST + i] = b1[i];
      end
      for (int i = 0; i < tvic_pkg::EXT2_COUNT; i++) begin
         m[tvic_pkg::EXT2_FIRST + i] = b2[i];
      end
      return m & tvic_pkg::VALID_POS;
   endfunction : spread

   // Enable and priority maps share one decoder.
   assign en_mask = spread(st_reg.en0, st_reg.en1, st_reg.en2);
   assign hi_mask = spread(st_reg.pr0, st_reg.pr1, st_reg.pr2);

   // Global enable gates every source; disabled flags are simply ignored.
   assign cand = st_reg.pend & en_mask
                 & {17{st_reg.en0[tvic_pkg::GLOBAL_BIT]}};

   // A high routine blocks all; a low one only lets high through.
   assign preempt_ok = !st_reg.act_hi
                       && (win_level || !st_reg.act_lo);

   tvic_arbiter #(
      .N_SRC (tvic_pkg::NUM_POS),
      .POS_W (tvic_pkg::POS_W)
   ) u_arb (
      .cand  (cand),
      .high  (hi_mask),
      .found (win_found),
      .pos   (win_pos),
      .level (win_level)
   );

   //***************************************************************************
   // Next state.
   //***************************************************************************
   logic [16:0] hw_clr;

   // Sampling and decode happen every cycle, so the request lags the flag by one.
   always_comb begin
      hw_clr  = '0;
      st_next = st_reg;
      case (st_reg.mode)
         tvic_pkg::ST_RUN: begin
            if (win_found && preempt_ok) begin
               st_next.req  = 1'b1;
               st_next.mode = tvic_pkg::ST_CALL;
            end
         end
         tvic_pkg::ST_CALL: begin
            if (cpu_ack) begin
               // Call begins: record level and clear self-clearing flags.
               st_next.req  = 1'b0;
               st_next.mode = tvic_pkg::ST_RUN;
               if (st_reg.lvl) begin
                  st_next.act_hi = 1'b1;
               end else begin
                  st_next.act_lo = 1'b1;
               end
               hw_clr = (17'h00001 << st_reg.pos) & tvic_pkg::HW_CLR_POS;
            end else if (!(win_found && preempt_ok)) begin
               // Flag withdrawn before the core took it.
               st_next.req  = 1'b0;
               st_next.mode = tvic_pkg::ST_RUN;
            end
         end
         tvic_pkg::ST_HOLD: begin
            // One full instruction must run after a return.
            if (cpu_instr_done) begin
               st_next.mode = tvic_pkg::ST_RUN;
            end
         end
         default: begin
            st_next.mode = tvic_pkg::ST_RUN;
            st_next.req  = 1'b0;
         end
      endcase

      // The winner is refreshed until the ack freezes it.
      if (st_next.req && !(st_reg.mode == tvic_pkg::ST_CALL && cpu_ack)) begin
         st_next.pos = win_pos;
         st_next.lvl = win_level;
         st_next.vec = tvic_pkg::VECTOR_BASE
                       + (16'(win_pos) << tvic_pkg::VECTOR_SHIFT);
      end

      // Return drops the newest level; high is always the newer when both set.
      if (cpu_return_done) begin
         if (st_reg.act_hi) begin
            st_next.act_hi = 1'b0;
         end else begin
            st_next.act_lo = 1'b0;
         end
         st_next.req  = 1'b0;
         st_next.mode = tvic_pkg::ST_HOLD;
      end

      // Sets win over any clear landing in the same cycle.
      st_next.pend = ((st_reg.pend & ~flag_clr_sw & ~hw_clr)
                      | src_event
                      | flag_set_sw)
                     & tvic_pkg::VALID_POS;

      // Register writes; reserved bits hold their fixed values.
      if (cfg_wr_sel[tvic_pkg::SEL_EN0]) begin
         st_next.en0 = cfg_wr_data;
      end
      if (cfg_wr_sel[tvic_pkg::SEL_EN1]) begin
         st_next.en1 = cfg_wr_data & tvic_pkg::EXT1_MASK;
      end
      if (cfg_wr_sel[tvic_pkg::SEL_EN2]) begin
         st_next.en2 = cfg_wr_data & tvic_pkg::EXT2_MASK;
      end
      if (cfg_wr_sel[tvic_pkg::SEL_PR0]) begin
         st_next.pr0 = cfg_wr_data | tvic_pkg::PR0_READ_ONE;
      end
      if (cfg_wr_sel[tvic_pkg::SEL_PR1]) begin
         st_next.pr1 = cfg_wr_data & tvic_pkg::EXT1_MASK;
      end
      if (cfg_wr_sel[tvic_pkg::SEL_PR2]) begin
         st_next.pr2 = cfg_wr_data & tvic_pkg::EXT2_MASK;
      end
   end

   //***************************************************************************
   // State register.
   //***************************************************************************
   // Reset parks the vector at the reset address with every priority low.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg.mode   <= tvic_pkg::ST_RUN;
         st_reg.pend   <= '0;
         st_reg.en0    <= tvic_pkg::REG_RESET;
         st_reg.en1    <= tvic_pkg::REG_RESET;
         st_reg.en2    <= tvic_pkg::REG_RESET;
         st_reg.pr0    <= tvic_pkg::PR0_RESET;
         st_reg.pr1    <= tvic_pkg::REG_RESET;
         st_reg.pr2    <= tvic_pkg::REG_RESET;
         st_reg.act_hi <= 1'b0;
         st_reg.act_lo <= 1'b0;
         st_reg.req    <= 1'b0;
         st_reg.lvl    <= 1'b0;
         st_reg.pos    <= '0;
         st_reg.vec    <= tvic_pkg::RESET_VECTOR;
      end else begin
         st_reg <= st_next;
      end
   end

   //***************************************************************************
   // Outputs, all straight from the state register.
   //***************************************************************************
   assign irq_req               = st_reg.req;
   assign irq_vector            = st_reg.vec;
   assign irq_level             = st_reg.lvl;
   assign irq_pos               = st_reg.pos;
   assign pending               = st_reg.pend;
   assign irq_enable_reg        = st_reg.en0;
   assign ext_irq_enable_reg1   = st_reg.en1;
   assign ext_irq_enable_reg2   = st_reg.en2;
   assign irq_priority_reg      = st_reg.pr0;
   assign ext_irq_priority_reg1 = st_reg.pr1;
   assign ext_irq_priority_reg2 = st_reg.pr2;
   assign active_high           = st_reg.act_hi;
   assign active_low            = st_reg.act_lo;

   //***************************************************************************
   // Assertions.
   //***************************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_idle_ready;
      st_reg.mode == tvic_pkg::ST_RUN && !st_reg.act_hi && !st_reg.act_lo
      && !cpu_return_done && (cand != '0);
   endsequence

   sequence s_return_then_step;
      cpu_return_done ##1 (!cpu_return_done && cpu_instr_done && !st_reg.act_hi
                           && !st_reg.act_lo && (cand != '0));
   endsequence

   a_flag_sets: assert property (
      (src_event != '0) |=> ((pending & $past(src_event & tvic_pkg::VALID_POS))
                             == $past(src_event & tvic_pkg::VALID_POS)))
      else $error("event did not set its pending flag");

   a_global_gate: assert property (
      !irq_enable_reg[tvic_pkg::GLOBAL_BIT] && !irq_req |=> !irq_req)
      else $error("request raised with global enable clear");

   a_enabled_only: assert property (
      $rose(irq_req) |-> $past(cand[st_next.pos]) || $past(cand[irq_pos]))
      else $error("request for a disabled or idle flag");

   a_fast_response: assert property (
      s_idle_ready |=> irq_req ##0
      irq_vector == tvic_pkg::VECTOR_BASE + {8'h00, irq_pos, 3'b000})
      else $error("request or vector late for idle controller");

   a_hw_clear: assert property (
      irq_req && cpu_ack && irq_pos < 5'h04
      && !src_event[irq_pos] && !flag_set_sw[irq_pos]
      |=> !pending[$past(irq_pos)])
      else $error("self-clearing flag still set after call");

   a_sw_keep: assert property (
      irq_req && cpu_ack && irq_pos >= 5'h04 && !flag_clr_sw[irq_pos]
      |=> pending[$past(irq_pos)])
      else $error("software-cleared flag dropped by hardware");

   a_return_hold: assert property (
      cpu_return_done ##1 !cpu_instr_done |=> !irq_req)
      else $error("request issued before the instruction after return");

   a_reentry: assert property (
      s_return_then_step |-> ##[1:2] irq_req)
      else $error("still pending flag not re-requested after return");

   a_high_blocks: assert property (
      active_high && !cpu_return_done && !irq_req |=> !irq_req)
      else $error("request during a high level routine");

   a_low_preempt: assert property (
      active_low && $rose(irq_req) |-> irq_level)
      else $error("low request preempted a low routine");

   a_ack_records: assert property (
      irq_req && cpu_ack && !cpu_return_done |=>
      (irq_level ? active_high : active_low) && !irq_req)
      else $error("ack did not record the active level");

endmodule : tvic_ctrl

/* File: test/tvic_cpu_model.sv */
//******************************************************************************
// Purpose: Core model that answers controller requests with a delayed ack.
// Assumes: It drives at the falling edge and the controller samples at the rising one.
// Notes:   The bench pulses return and instruction ends itself.
//******************************************************************************
`timescale 1ns/1ps
module tvic_cpu_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        ack_en,
   input  wire logic [3:0]  ack_dly,
   input  wire logic        irq_req,
   input  wire logic [15:0] irq_vector,
   output logic             cpu_ack,
   output logic [15:0]      took_vec,
   output int               calls
);
   logic [3:0] wait_cnt;

   // A request must stand for ack_dly cycles before the model acks it, as a core
   // that is still finishing a long instruction would. A request that vanishes
   // restarts the count.
   always @(negedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_ack  <= 1'b0;
         took_vec <= 16'h0000;
         calls    <= 0;
         wait_cnt <= 4'h0;
      end else begin
         cpu_ack <= 1'b0;
         if (irq_req && ack_en && !cpu_ack && wait_cnt == ack_dly) begin
            cpu_ack  <= 1'b1;
            took_vec <= irq_vector;
            calls    <= calls + 1;
            wait_cnt <= 4'h0;
         end else if (irq_req && ack_en) begin
            wait_cnt <= wait_cnt + 4'h1;
         end else begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule : tvic_cpu_model

/* File: test/tvic_ctrl_tb.sv */
//******************************************************************************
// Purpose: Self-checking bench for the two level vectored irq controller.
// Assumes: Inputs change at the falling edge. The core model acks requests.
// Notes:   Only mismatches and the verdict are printed.
//******************************************************************************
`timescale 1ns/1ps
module tvic_ctrl_tb;
   logic        clk, arst_n, ack_en, cpu_ack, cpu_return_done, cpu_instr_done;
   logic        irq_req, irq_level, active_high, active_low;
   logic [16:0] src_event, flag_set_sw, flag_clr_sw, pending;
   logic [5:0]  cfg_wr_sel;
   logic [7:0]  cfg_wr_data, irq_enable_reg, ext_irq_enable_reg1, ext_irq_enable_reg2;
   logic [7:0]  irq_priority_reg, ext_irq_priority_reg1, ext_irq_priority_reg2;
   logic [15:0] irq_vector, took_vec;
   logic [4:0]  irq_pos;
   logic [3:0]  ack_dly;
   int          calls, bad_count, comparisons;

   tvic_ctrl dut (.clk, .arst_n, .src_event, .flag_set_sw, .flag_clr_sw, .cfg_wr_sel,
      .cfg_wr_data, .cpu_ack, .cpu_return_done, .cpu_instr_done, .irq_req, .irq_vector,
      .irq_level, .irq_pos, .pending, .irq_enable_reg, .ext_irq_enable_reg1,
      .ext_irq_enable_reg2, .irq_priority_reg, .ext_irq_priority_reg1,
      .ext_irq_priority_reg2, .active_high, .active_low);
   tvic_cpu_model core (.clk, .arst_n, .ack_en, .ack_dly, .irq_req, .irq_vector,
      .cpu_ack, .took_vec, .calls);

   // This is a 100 MHz system clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   //***************************************************************************
   // Tasks
   //***************************************************************************
   // Each task starts at a falling edge and returns at one. Every pulse is
   // therefore taken by exactly one rising edge.
   task automatic pulse(input int k, input logic [16:0] m, input logic [7:0] d);
      cfg_wr_data = d;
      case (k)
         0: src_event = m;
         1: flag_set_sw = m;
         2: flag_clr_sw = m;
         3: cfg_wr_sel = m[5:0];
         4: cpu_return_done = m[0];
         default: cpu_instr_done = m[0];
      endcase
      @(negedge clk);
      {src_event, flag_set_sw, flag_clr_sw, cfg_wr_sel, cpu_return_done, cpu_instr_done} = '0;
   endtask : pulse

   task automatic wr(input int r, input logic [7:0] d);
      pulse(3, 17'(1 << r), d);
   endtask : wr

   task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // This waits a bounded time for the core model to take a call. It returns
   // once the edge that took the ack has updated the controller.
   task automatic wait_call();
      int c0;
      c0 = calls;
      for (int i = 0; i < 20 && calls == c0; i++) @(posedge clk);
      @(negedge clk);
      chk("call", 17'h1, 17'(calls != c0));
   endtask : wait_call

   // This enables a single position and keeps the global enable set.
   task automatic en_only(input int n);
      wr(0, n < 7 ? 8'h80 | 8'(1 << n) : 8'h80);
      wr(1, (n > 6 && n < 13) ? 8'(1 << (n - 7)) : 8'h00);
      wr(2, n > 14 ? 8'(1 << (n - 15)) : 8'h00);
   endtask : en_only

   task automatic final_report();
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report

   // The whole run takes well under a thousand cycles, so a hang stops here.
   initial begin
      repeat (4000) @(posedge clk);
      bad_count++;
      final_report();
   end

   //***************************************************************************
   // Scenarios
   //***************************************************************************
   initial begin
      {src_event, flag_set_sw, flag_clr_sw, cfg_wr_sel, cfg_wr_data} = '0;
      {cpu_return_done, cpu_instr_done, ack_en} = '0;
      ack_dly = 4'h2;
      arst_n = 1'b0;
      bad_count = 0;
      comparisons = 0;
      repeat (10) @(negedge clk);
      arst_n = 1'b1;
      chk("ip", 17'h80, irq_priority_reg);
      chk("eip", 17'h0, {ext_irq_priority_reg1, ext_irq_priority_reg2});
      chk("vec", 17'h0, irq_vector);
      chk("en", 17'h0, {irq_enable_reg, ext_irq_enable_reg1});
      // Reserved bits are masked, and priority bit 7 always reads one.
      wr(1, 8'hff);
      wr(2, 8'hff);
      wr(3, 8'h00);
      wr(4, 8'hff);
      chk("eie", 17'h3f03, {ext_irq_enable_reg1, ext_irq_enable_reg2});
      chk("pri", 17'h803f, {irq_priority_reg, ext_irq_priority_reg1});
      wr(4, 8'h00);
      wr(0, 8'h10);
      pulse(0, 17'h06010, 8'h00);
      chk("pend", 17'h00010, pending);
      repeat (3) @(negedge clk);
      chk("req", 17'h0, irq_req);
      wr(0, 8'h80);
      repeat (3) @(negedge clk);
      chk("req", 17'h0, irq_req);
      chk("pend", 17'h00010, pending);
      wr(0, 8'h90);
      chk("req", 17'h0, irq_req);
      @(negedge clk);
      chk("req", 17'h1, irq_req);
      chk("vec", 17'h0023, irq_vector);
      chk("lvl", 17'h04, {irq_level, irq_pos});
      pulse(2, 17'h10, 8'h00);
      @(negedge clk);
      chk("req", 17'h0, irq_req);
      // Every usable position, entered through its own enable bit.
      ack_en = 1'b1;
      for (int n = 0; n < 17; n++) begin
         if (n < 13 || n > 14) begin
            en_only(n);
            pulse(1, 17'(1 << n), 8'h00);
            wait_call();
            chk("vec", 16'h0003 + 16'(8 * n), took_vec);
            chk("pend", n > 3 ? 17'(1 << n) : 17'h0, pending);
            chk("act", 17'h1, active_low);
            pulse(2, 17'(1 << n), 8'h00);
            pulse(4, 17'h1, 8'h00);
            chk("act", 17'h0, active_low);
            pulse(5, 17'h1, 8'h00);
         end
      end
      // Nesting: only high preempts low, and nothing preempts high.
      ack_dly = 4'h0;
      wr(3, 8'h01);
      wr(0, 8'h97);
      pulse(1, 17'h10, 8'h00);
      wait_call();
      pulse(1, 17'h02, 8'h00);
      repeat (4) @(negedge clk);
      chk("req", 17'h0, irq_req);
      pulse(1, 17'h01, 8'h00);
      wait_call();
      chk("vec", 17'h0003, took_vec);
      chk("act", 17'h3, {active_high, active_low});
      wr(3, 8'h05);
      pulse(1, 17'h04, 8'h00);
      repeat (4) @(negedge clk);
      chk("req", 17'h0, irq_req);
      pulse(4, 17'h1, 8'h00);
      chk("act", 17'h1, {active_high, active_low});
      repeat (3) @(negedge clk);
      chk("req", 17'h0, irq_req);
      pulse(5, 17'h1, 8'h00);
      wait_call();
      chk("vec", 17'h0013, took_vec);
      pulse(2, 17'h04, 8'h00);
      pulse(4, 17'h1, 8'h00);
      pulse(5, 17'h1, 8'h00);
      repeat (3) @(negedge clk);
      chk("req", 17'h0, irq_req);
      pulse(4, 17'h1, 8'h00);
      pulse(5, 17'h1, 8'h00);
      wait_call();
      chk("vec", 17'h000b, took_vec);
      pulse(2, 17'h12, 8'h00);
      pulse(4, 17'h1, 8'h00);
      pulse(5, 17'h1, 8'h00);
      // Several requests at once: first by level, then by position.
      ack_en = 1'b0;
      wr(0, 8'hff);
      wr(2, 8'h03);
      pulse(1, 17'h10030, 8'h00);
      @(negedge clk);
      chk("lvl", 17'h04, {irq_level, irq_pos});
      wr(5, 8'h02);
      @(negedge clk);
      chk("lvl", 17'h30, {irq_level, irq_pos});
      chk("vec", 17'h0083, irq_vector);
      wr(0, 8'h7f);
      @(negedge clk);
      chk("req", 17'h0, irq_req);
      final_report();
   end
endmodule : tvic_ctrl_tb
